// ==== tsense_pkg.sv ====
// Purpose: shared constants and types for the conversion sequencer and its host controller
// Assumes: one 125 MHz clock for both ends
// Notes: device ram addresses are byte addresses; words are stored msb first
package tsense_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] CMD_ADDR = 12'h000;
  localparam logic [11:0] RESULT_BASE = 12'h010;
  localparam logic [11:0] RESULT_LAST = 12'h05f;
  localparam logic [11:0] ASSIGN_BASE = 12'h200;
  localparam logic [11:0] ASSIGN_LAST = 12'h24f;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam int START_FLAG_BIT = 7;
  localparam int DONE_FLAG_BIT = 6;
  localparam int PAD_BIT = 5;
  localparam logic [4:0] CH_SCAN = 5'h00;
  localparam logic [4:0] CH_FIRST = 5'h01;
  localparam logic [4:0] CH_LAST = 5'h14;
  localparam logic [4:0] CH_SLEEP = 5'h17;
  localparam int CH_COUNT = 20;
  localparam int TYPE_MSB = 31;
  localparam int TYPE_LSB = 27;
  localparam logic [4:0] TYPE_NONE = 5'h00;
  localparam logic [4:0] TYPE_TC_LAST = 5'h09;
  localparam logic [4:0] TYPE_TC_CUSTOM = 5'h09;
  localparam logic [4:0] TYPE_RTD_LAST = 5'h12;
  localparam logic [4:0] TYPE_RTD_CUSTOM = 5'h12;
  localparam logic [4:0] TYPE_THERM_LAST = 5'h1b;
  localparam logic [4:0] TYPE_THERM_CUSTOM = 5'h1a;
  localparam logic [4:0] TYPE_DIODE = 5'h1c;
  localparam logic [4:0] TYPE_RSENSE = 5'h1d;
  localparam logic [4:0] TYPE_ADC = 5'h1e;
  localparam int PARTNER_LSB = 22;
  localparam int SGL_DIODE_BIT = 26;
  localparam int SGL_THERM_BIT = 21;
  localparam int EXC_LSB = 14;
  localparam int CUST_ADDR_LSB = 6;
  localparam int CUST_LEN_LSB = 0;
  localparam int VALID_BIT = 24;
  localparam int FAULT_LSB = 25;
  localparam int MEAS_CYCLE_MS = 82;
  localparam int CLK_HZ = 125_000_000;
  localparam int MEAS_CYCLE_CLKS = MEAS_CYCLE_MS * (CLK_HZ / 1000);
  localparam logic [1:0] CYCLES_SHORT = 2'h2;
  localparam logic [1:0] CYCLES_LONG = 2'h3;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_IRQ_STAT = 8'h14;
  localparam logic [7:0] REG_IRQ_MASK = 8'h18;
  localparam int CTRL_GO = 0;
  localparam int CTRL_WRITE = 1;
  localparam int CTRL_CONV = 2;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_XFER = 1;
  localparam int IRQ_REFUSED = 2;
  localparam int IRQ_W = 3;
  typedef enum logic [2:0] {
    CLS_NONE = 3'h0, CLS_TC = 3'h1, CLS_RTD = 3'h2, CLS_THERM = 3'h3,
    CLS_DIODE = 3'h4, CLS_RSENSE = 3'h5, CLS_ADC = 3'h6, CLS_RSVD = 3'h7
  } sensor_class_type;
endpackage

// ==== tsense_link_if.sv ====
// Purpose: ram access and completion link between host controller and sequencer
// Assumes: both ends on i_sys_clk
// Notes: req is held until ack; ack is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface tsense_link_if;
  logic req;
  logic we;
  logic [11:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;
  logic refused;
  logic conv_done;
  modport device(input req, input we, input addr, input wdata,
    output rdata, output ack, output refused, output conv_done);
  modport host(output req, output we, output addr, output wdata,
    input rdata, input ack, input refused, input conv_done);
endinterface
`default_nettype wire

// ==== sensor_assignment_decoder.sv ====
// Purpose: split a channel assignment word into sensor class and settings
// Assumes: word laid out msb first as stored in assignment ram
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module sensor_assignment_decoder (
  input wire logic [31:0] i_word,
  output tsense_pkg::sensor_class_type o_class,
  output logic o_custom,
  output logic o_needs_partner,
  output logic [4:0] o_partner_ch,
  output logic o_single_ended,
  output logic [3:0] o_excitation,
  output logic [5:0] o_custom_addr,
  output logic [5:0] o_custom_len
);
  wire logic [4:0] sensor_type = i_word[tsense_pkg::TYPE_MSB:tsense_pkg::TYPE_LSB];

  always_comb begin
    if (sensor_type == tsense_pkg::TYPE_NONE) begin
      o_class = tsense_pkg::CLS_NONE;
    end else if (sensor_type <= tsense_pkg::TYPE_TC_LAST) begin
      o_class = tsense_pkg::CLS_TC;
    end else if (sensor_type <= tsense_pkg::TYPE_RTD_LAST) begin
      o_class = tsense_pkg::CLS_RTD;
    end else if (sensor_type <= tsense_pkg::TYPE_THERM_LAST) begin
      o_class = tsense_pkg::CLS_THERM;
    end else if (sensor_type == tsense_pkg::TYPE_DIODE) begin
      o_class = tsense_pkg::CLS_DIODE;
    end else if (sensor_type == tsense_pkg::TYPE_RSENSE) begin
      o_class = tsense_pkg::CLS_RSENSE;
    end else if (sensor_type == tsense_pkg::TYPE_ADC) begin
      o_class = tsense_pkg::CLS_ADC;
    end else begin
      o_class = tsense_pkg::CLS_RSVD;
    end
  end

  assign o_custom = (sensor_type == tsense_pkg::TYPE_TC_CUSTOM) |
    (sensor_type == tsense_pkg::TYPE_RTD_CUSTOM) |
    (sensor_type >= tsense_pkg::TYPE_THERM_CUSTOM &&
     sensor_type <= tsense_pkg::TYPE_THERM_LAST);
  // cold junction or sense resistor pointer
  assign o_needs_partner = (o_class == tsense_pkg::CLS_TC) |
    (o_class == tsense_pkg::CLS_RTD) | (o_class == tsense_pkg::CLS_THERM);
  assign o_partner_ch = o_needs_partner ?
    i_word[tsense_pkg::PARTNER_LSB +: 5] : 5'h00;
  assign o_single_ended = (o_class == tsense_pkg::CLS_THERM) ?
    i_word[tsense_pkg::SGL_THERM_BIT] : i_word[tsense_pkg::SGL_DIODE_BIT];
  assign o_excitation = i_word[tsense_pkg::EXC_LSB +: 4];
  assign o_custom_addr = i_word[tsense_pkg::CUST_ADDR_LSB +: 6];
  assign o_custom_len = i_word[tsense_pkg::CUST_LEN_LSB +: 6];
endmodule
`default_nettype wire

// ==== conversion_command_sequencer.sv ====
// Purpose: device end: command/status byte, assignment and result ram, conversion timing
// Assumes: analog front end outside supplies temperature and fault bits at cycle end
// Notes: one link request in flight at a time
// Notes on behaviour
// - bits 31:27 of assignment give sensor type
// - other assignment bits carry type-specific settings
// - host starts with byte 10 0 channel at zero
// - channel zero runs a multi-channel scan
// - channels 1-20 single, 23 sleep, others reserved
// - host writes command bit 5 as zero
// - completion output low throughout a conversion
// - on completion flags become 01, output high
// - sensor and its partner channel measured together
// - during conversion only reading location zero allowed
// - conversion takes two or three 82 ms cycles
// - host sees end by edge or polling flags
// - results readable at 0x010 through 0x05f
// - result bit 24 valid, 31:25 fault flags
// - after completion new commands and assignment writes accepted
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module conversion_command_sequencer #(
  parameter int unsigned CYCLE_CLKS = tsense_pkg::MEAS_CYCLE_CLKS
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  tsense_link_if.device link,
  output logic o_meas_start,
  output logic [4:0] o_meas_ch,
  output logic [4:0] o_meas_partner_ch,
  output logic [4:0] o_meas_type,
  output logic [1:0] o_meas_cycles,
  output logic o_busy,
  output logic o_sleep,
  input wire logic [23:0] i_meas_temp,
  input wire logic [6:0] i_meas_fault
);
  localparam int CNT_W = $clog2(CYCLE_CLKS + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(CYCLE_CLKS - 1);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOAD = 3'b001,
    ST_MEAS = 3'b011,
    ST_STORE = 3'b010,
    ST_NEXT = 3'b110,
    ST_SLEEP = 3'b100
  } seq_state_type;

  seq_state_type state_reg;
  logic [7:0] cmd_reg;
  logic [31:0] asg_mem [0:tsense_pkg::CH_COUNT-1];
  logic [31:0] result_mem [0:tsense_pkg::CH_COUNT-1];
  logic [4:0] chi_reg;
  logic scan_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [1:0] cyc_left_reg;
  logic ack_reg;
  logic refused_reg;
  logic [7:0] rdata_reg;
  logic conv_done_reg;
  logic meas_start_reg;
  logic [4:0] meas_ch_reg;
  logic [4:0] meas_partner_reg;
  logic [4:0] meas_type_reg;
  logic [1:0] meas_cycles_reg;

  // access decode
  wire logic idle_like = (state_reg == ST_IDLE) | (state_reg == ST_SLEEP);
  wire logic take = link.req & ~ack_reg;
  wire logic is_cmd = (link.addr == tsense_pkg::CMD_ADDR);
  wire logic in_res = (link.addr >= tsense_pkg::RESULT_BASE) &&
    (link.addr <= tsense_pkg::RESULT_LAST);
  wire logic in_asg = (link.addr >= tsense_pkg::ASSIGN_BASE) &&
    (link.addr <= tsense_pkg::ASSIGN_LAST);
  wire logic allowed = idle_like | (is_cmd & ~link.we);
  wire logic wr_ok = take & link.we & allowed;
  wire logic cmd_wr = wr_ok & is_cmd;
  wire logic asg_wr = wr_ok & in_asg;
  wire logic [11:0] res_off = link.addr - tsense_pkg::RESULT_BASE;
  wire logic [11:0] asg_off = link.addr - tsense_pkg::ASSIGN_BASE;
  wire logic [31:0] res_word = result_mem[res_off[6:2]];
  wire logic [31:0] asg_word = asg_mem[asg_off[6:2]];
  wire logic [7:0] res_byte = res_word[{~res_off[1:0], 3'b000} +: 8];
  wire logic [7:0] asg_byte = asg_word[{~asg_off[1:0], 3'b000} +: 8];
  wire logic [7:0] rdata_next = ~allowed ? 8'h00 :
    is_cmd ? cmd_reg : in_res ? res_byte : in_asg ? asg_byte : 8'h00;

  // command decode
  wire logic [4:0] sel = link.wdata[4:0];
  wire logic start_cmd = link.wdata[tsense_pkg::START_FLAG_BIT] &
    ~link.wdata[tsense_pkg::DONE_FLAG_BIT] & ~link.wdata[tsense_pkg::PAD_BIT];
  wire logic go_scan = cmd_wr & start_cmd & (sel == tsense_pkg::CH_SCAN);
  wire logic go_single = cmd_wr & start_cmd & (sel >= tsense_pkg::CH_FIRST) &&
    (sel <= tsense_pkg::CH_LAST);
  wire logic go_sleep = cmd_wr & start_cmd & (sel == tsense_pkg::CH_SLEEP);
  wire logic go_conv = go_scan | go_single;

  // current channel decode
  tsense_pkg::sensor_class_type cur_class;
  logic cur_needs_partner;
  logic [4:0] cur_partner;
  sensor_assignment_decoder u_decode (
    .i_word(asg_mem[chi_reg]),
    .o_class(cur_class),
    .o_custom(),
    .o_needs_partner(cur_needs_partner),
    .o_partner_ch(cur_partner),
    .o_single_ended(),
    .o_excitation(),
    .o_custom_addr(),
    .o_custom_len()
  );
  wire logic skip_ch = scan_reg & ((cur_class == tsense_pkg::CLS_NONE) |
    (cur_class == tsense_pkg::CLS_RSENSE) | (cur_class == tsense_pkg::CLS_RSVD));
  wire logic [1:0] cur_cycles = (cur_needs_partner && cur_partner != 5'h00) ?
    tsense_pkg::CYCLES_LONG : tsense_pkg::CYCLES_SHORT;
  wire logic hard_fault = |i_meas_fault[6:4];
  wire logic [31:0] result_word = {i_meas_fault, ~hard_fault, i_meas_temp};
  wire logic last_ch = ~scan_reg | (chi_reg == 5'(tsense_pkg::CH_COUNT - 1));

  // link answer: one cycle after the request
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ack_reg <= 1'b0;
      refused_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      ack_reg <= take;
      refused_reg <= take & ~allowed;
      if (take) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // assignment ram: host byte writes while idle
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      for (int i = 0; i < tsense_pkg::CH_COUNT; i++) begin
        asg_mem[i] <= 32'h0000_0000;
      end
    end else if (asg_wr) begin
      asg_mem[asg_off[6:2]][{~asg_off[1:0], 3'b000} +: 8] <= link.wdata;
    end
  end

  // result ram: read-only to the host
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      for (int i = 0; i < tsense_pkg::CH_COUNT; i++) begin
        result_mem[i] <= 32'h0000_0000;
      end
    end else if (state_reg == ST_STORE) begin
      result_mem[chi_reg] <= result_word;
    end
  end

  // command byte and completion output
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cmd_reg <= tsense_pkg::CMD_RESET;
      conv_done_reg <= 1'b1;
    end else if (cmd_wr) begin
      cmd_reg <= link.wdata;
      conv_done_reg <= ~go_conv;
    end else if (state_reg == ST_NEXT && last_ch) begin
      cmd_reg[tsense_pkg::START_FLAG_BIT] <= 1'b0;
      cmd_reg[tsense_pkg::DONE_FLAG_BIT] <= 1'b1;
      conv_done_reg <= 1'b1;
    end
  end

  // sequencer
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state_reg <= ST_IDLE;
      chi_reg <= 5'h00;
      scan_reg <= 1'b0;
      cnt_reg <= '0;
      cyc_left_reg <= 2'h0;
    end else begin
      case (state_reg)
        ST_IDLE, ST_SLEEP: begin
          if (go_conv) begin
            scan_reg <= go_scan;
            chi_reg <= go_scan ? 5'h00 : sel - 5'h01;
            state_reg <= ST_LOAD;
          end else if (go_sleep) begin
            state_reg <= ST_SLEEP;
          end else if (cmd_wr) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_LOAD: begin
          if (skip_ch) begin
            state_reg <= ST_NEXT;
          end else begin
            cyc_left_reg <= cur_cycles;
            cnt_reg <= CNT_LOAD;
            state_reg <= ST_MEAS;
          end
        end
        ST_MEAS: begin
          if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - CNT_W'(1);
          end else if (cyc_left_reg == 2'h1) begin
            state_reg <= ST_STORE;
          end else begin
            cyc_left_reg <= cyc_left_reg - 2'h1;
            cnt_reg <= CNT_LOAD;
          end
        end
        ST_STORE: begin
          state_reg <= ST_NEXT;
        end
        ST_NEXT: begin
          if (last_ch) begin
            state_reg <= ST_IDLE;
          end else begin
            chi_reg <= chi_reg + 5'h01;
            state_reg <= ST_LOAD;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // measurement request toward the front end
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      meas_start_reg <= 1'b0;
      meas_ch_reg <= 5'h00;
      meas_partner_reg <= 5'h00;
      meas_type_reg <= 5'h00;
      meas_cycles_reg <= 2'h0;
    end else begin
      meas_start_reg <= (state_reg == ST_LOAD) & ~skip_ch;
      if (state_reg == ST_LOAD && !skip_ch) begin
        meas_ch_reg <= chi_reg + 5'h01;
        meas_partner_reg <= cur_partner;
        meas_type_reg <= asg_mem[chi_reg][tsense_pkg::TYPE_MSB:tsense_pkg::TYPE_LSB];
        meas_cycles_reg <= cur_cycles;
      end
    end
  end

  assign link.ack = ack_reg;
  assign link.refused = refused_reg;
  assign link.rdata = rdata_reg;
  assign link.conv_done = conv_done_reg;
  assign o_meas_start = meas_start_reg;
  assign o_meas_ch = meas_ch_reg;
  assign o_meas_partner_ch = meas_partner_reg;
  assign o_meas_type = meas_type_reg;
  assign o_meas_cycles = meas_cycles_reg;
  assign o_busy = ~idle_like;
  assign o_sleep = (state_reg == ST_SLEEP);
endmodule
`default_nettype wire

// ==== tsense_host_ctrl.sv ====
// Purpose: host end: apb registers that drive single ram accesses over the link
// Assumes: apb master on i_sys_clk; zero wait states
// Notes: irq status is write-one-to-clear, set wins over clear
`timescale 1ns/1ps
`default_nettype none
module tsense_host_ctrl (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_irq,
  tsense_link_if.host link
);
  logic [11:0] addr_reg;
  logic [7:0] wdata_reg;
  logic [7:0] rdata_reg;
  logic busy_reg;
  logic we_reg;
  logic [11:0] lk_addr_reg;
  logic [7:0] lk_wdata_reg;
  logic refused_reg;
  logic done_prev_reg;
  logic [tsense_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [tsense_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;

  wire logic setup = i_psel & ~i_penable;
  wire logic wr_en = i_psel & i_penable & i_pwrite;
  wire logic sel_ctrl = (i_paddr == tsense_pkg::REG_CTRL);
  wire logic sel_addr = (i_paddr == tsense_pkg::REG_ADDR);
  wire logic sel_wdata = (i_paddr == tsense_pkg::REG_WDATA);
  wire logic sel_rdata = (i_paddr == tsense_pkg::REG_RDATA);
  wire logic sel_status = (i_paddr == tsense_pkg::REG_STATUS);
  wire logic sel_stat = (i_paddr == tsense_pkg::REG_IRQ_STAT);
  wire logic sel_mask = (i_paddr == tsense_pkg::REG_IRQ_MASK);
  wire logic mapped = sel_ctrl | sel_addr | sel_wdata | sel_rdata | sel_status |
    sel_stat | sel_mask;
  wire logic go = wr_en & sel_ctrl & i_pwdata[tsense_pkg::CTRL_GO] & ~busy_reg;
  wire logic conv = i_pwdata[tsense_pkg::CTRL_CONV];
  wire logic [7:0] conv_byte = {2'b10, 1'b0, wdata_reg[4:0]};
  wire logic [7:0] plain_byte = (addr_reg == tsense_pkg::CMD_ADDR) ?
    (wdata_reg & 8'hdf) : wdata_reg;
  wire logic done_rise = link.conv_done & ~done_prev_reg;
  wire logic [tsense_pkg::IRQ_W-1:0] irq_set =
    {link.ack & link.refused, link.ack, done_rise};
  wire logic [tsense_pkg::IRQ_W-1:0] irq_clr =
    (wr_en & sel_stat) ? i_pwdata[tsense_pkg::IRQ_W-1:0] : '0;
  wire logic [31:0] status_word = {29'h0, refused_reg, link.conv_done, busy_reg};
  wire logic [31:0] rd_mux =
    sel_addr ? {20'h0, addr_reg} :
    sel_wdata ? {24'h0, wdata_reg} :
    sel_rdata ? {24'h0, rdata_reg} :
    sel_status ? status_word :
    sel_stat ? {29'h0, irq_stat_reg} :
    sel_mask ? {29'h0, irq_mask_reg} : 32'h0000_0000;

  // apb read data and error taken in the setup cycle
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (setup) begin
      prdata_reg <= i_pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_reg <= ~mapped;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      addr_reg <= 12'h000;
      wdata_reg <= 8'h00;
      irq_mask_reg <= '0;
    end else if (wr_en) begin
      if (sel_addr) begin
        addr_reg <= i_pwdata[11:0];
      end
      if (sel_wdata) begin
        wdata_reg <= i_pwdata[7:0];
      end
      if (sel_mask) begin
        irq_mask_reg <= i_pwdata[tsense_pkg::IRQ_W-1:0];
      end
    end
  end

  // link master: hold request until ack
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      busy_reg <= 1'b0;
      we_reg <= 1'b0;
      lk_addr_reg <= 12'h000;
      lk_wdata_reg <= 8'h00;
      rdata_reg <= 8'h00;
      refused_reg <= 1'b0;
    end else if (go) begin
      busy_reg <= 1'b1;
      we_reg <= conv | i_pwdata[tsense_pkg::CTRL_WRITE];
      lk_addr_reg <= conv ? tsense_pkg::CMD_ADDR : addr_reg;
      lk_wdata_reg <= conv ? conv_byte : plain_byte;
    end else if (busy_reg && link.ack) begin
      busy_reg <= 1'b0;
      refused_reg <= link.refused;
      if (!we_reg) begin
        rdata_reg <= link.rdata;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      done_prev_reg <= 1'b1;
      irq_stat_reg <= '0;
    end else begin
      done_prev_reg <= link.conv_done;
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
    end
  end

  assign link.req = busy_reg;
  assign link.we = we_reg;
  assign link.addr = lk_addr_reg;
  assign link.wdata = lk_wdata_reg;
  assign o_prdata = prdata_reg;
  assign o_pready = 1'b1;
  assign o_pslverr = pslverr_reg;
  assign o_irq = |(irq_stat_reg & irq_mask_reg);
endmodule
`default_nettype wire

// ==== tsense_link_asserts.sv ====
// Purpose: link protocol checks between host controller and sequencer
// Assumes: one clock, synchronous active-low reset
// Notes: CYCLE_CLKS must match the sequencer instance
`timescale 1ns/1ps
`default_nettype none
module tsense_link_asserts #(
  parameter int unsigned CYCLE_CLKS = tsense_pkg::MEAS_CYCLE_CLKS
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic req,
  input wire logic we,
  input wire logic [11:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic ack,
  input wire logic refused,
  input wire logic conv_done
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  wire take = req && !ack;
  wire at0 = addr == tsense_pkg::CMD_ADDR;
  wire start = take && we && at0 && wdata[7:5] == 3'h4 && wdata[4:0] <= 5'h14;
  logic [31:0] low_cnt;
  logic scan_run;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || conv_done) low_cnt <= 32'h0000_0000;
    else low_cnt <= low_cnt + 32'h0000_0001;
  end
  // a scan stores one result per assigned channel except sense resistor and reserved-type channels, so only its upper bound is fixed
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      scan_run <= 1'b0;
    end else if (conv_done && start) begin
      scan_run <= (wdata[4:0] == 5'h00);
    end
  end
  a_ack_follows_take: assert property (take |=> ack)
    else $error("no ack one cycle after request");
  a_ack_one_pulse: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_refused_no_data: assert property (refused |-> ack && rdata == 8'h00)
    else $error("refused without ack or with data");
  a_lockout_refuses: assert property (!conv_done && take && (we || !at0) |=> refused)
    else $error("access during conversion not refused");
  a_status_read_ok: assert property (!conv_done && take && !we && at0 |=> !refused)
    else $error("status read refused");
  a_idle_accepts: assert property (conv_done && take |=> !refused)
    else $error("access refused while idle");
  a_start_lowers: assert property (conv_done && start |=> !conv_done)
    else $error("completion output not lowered by start");
  a_done_holds: assert property ($fell(conv_done) |-> !conv_done [*8])
    else $error("completion output rose too early");
  a_conv_length: assert property ($rose(conv_done) |->
    (scan_run ? (low_cnt <= 20 * (3 * CYCLE_CLKS + 8)) :
    (low_cnt >= 2 * CYCLE_CLKS && low_cnt <= 3 * CYCLE_CLKS + 8)))
    else $error("conversion length out of range");
endmodule
`default_nettype wire

// ==== tb_conversion_command_sequencer.sv ====
// Purpose: drive sequencer through host controller apb registers
// Assumes: CYCLE_CLKS shortened to 64 clocks
// Notes: ram accesses go through ADDR, WDATA, CTRL and STATUS polling
`timescale 1ns/1ps
`default_nettype none
module tb_conversion_command_sequencer;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [23:0] temp = 24'h0;
  logic [6:0] fault = 7'h00;
  logic [31:0] prdata, s, w, lst;
  logic pready, pslverr, irq, busy, slp, serr, mst;
  logic [4:0] mch, mpart, mtype;
  logic [1:0] mcyc;
  logic [7:0] b;
  int n_mismatch = 0;
  int total_checks = 0;
  int n_start = 0;
  always #4 sys_clk = ~sys_clk;
  // counts measurement start pulses toward the front end
  always @(posedge sys_clk) begin
    if (mst === 1'b1) n_start++;
  end
  tsense_link_if tsense_link_if_i();
  conversion_command_sequencer #(.CYCLE_CLKS(64)) conversion_command_sequencer_i (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .link(tsense_link_if_i), .o_meas_start(mst),
    .o_meas_ch(mch), .o_meas_partner_ch(mpart), .o_meas_type(mtype), .o_meas_cycles(mcyc),
    .o_busy(busy), .o_sleep(slp), .i_meas_temp(temp), .i_meas_fault(fault));
  tsense_host_ctrl tsense_host_ctrl_i (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_irq(irq), .link(tsense_link_if_i));
  tsense_link_asserts #(.CYCLE_CLKS(64)) tsense_link_asserts_i (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .req(tsense_link_if_i.req),
    .we(tsense_link_if_i.we), .addr(tsense_link_if_i.addr), .wdata(tsense_link_if_i.wdata),
    .rdata(tsense_link_if_i.rdata), .ack(tsense_link_if_i.ack),
    .refused(tsense_link_if_i.refused), .conv_done(tsense_link_if_i.conv_done));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    pen <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic link_wait;
    lst = 32'h1;
    while (lst[0] !== 1'b0) apb(1'b0, tsense_pkg::REG_STATUS, 32'h0, lst);
  endtask
  task automatic ram(input logic wrt, input logic [11:0] a, input logic [7:0] d);
    wr(tsense_pkg::REG_ADDR, {20'h0, a});
    wr(tsense_pkg::REG_WDATA, {24'h0, d});
    wr(tsense_pkg::REG_CTRL, {30'h0, wrt, 1'b1});
    link_wait();
    apb(1'b0, tsense_pkg::REG_RDATA, 32'h0, s);
    b = s[7:0];
  endtask
  task automatic rdw(input logic [11:0] a);
    for (int i = 0; i < 4; i++) begin
      ram(1'b0, a + 12'(i), 8'h00);
      w[31 - 8 * i -: 8] = b;
    end
  endtask
  task automatic go(input logic [7:0] cmd);
    wr(tsense_pkg::REG_WDATA, {24'h0, cmd});
    wr(tsense_pkg::REG_CTRL, 32'h5);
    link_wait();
  endtask
  task automatic wait_done;
    s = 32'h0;
    while (s[1] !== 1'b1) apb(1'b0, tsense_pkg::REG_STATUS, 32'h0, s);
  endtask
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    apb(1'b0, tsense_pkg::REG_STATUS, 32'h0, s);
    chk(s, 32'h2);
    ram(1'b1, 12'h208, 8'h08);
    ram(1'b0, 12'h208, 8'h00);
    chk(b, 8'h08);
    ram(1'b1, 12'h210, 8'h50);
    ram(1'b1, 12'h211, 8'hc0);
    temp <= 24'h123456;
    go(8'h83);
    chk({busy, mtype, mch, mcyc}, {1'b1, 5'h01, 5'h03, 2'h2});
    ram(1'b0, 12'h000, 8'h00);
    chk({lst[2], b}, {1'b0, 8'h83});
    ram(1'b1, 12'h208, 8'hff);
    chk(lst[2], 1'b1);
    ram(1'b0, 12'h018, 8'h00);
    chk(lst[2], 1'b1);
    wait_done();
    ram(1'b0, 12'h000, 8'h00);
    chk(b, 8'h43);
    apb(1'b0, tsense_pkg::REG_IRQ_STAT, 32'h0, s);
    chk({s[0], irq}, 2'h2);
    rdw(12'h018);
    chk(w, 32'h01123456);
    ram(1'b0, 12'h208, 8'h00);
    chk(b, 8'h08);
    wr(tsense_pkg::REG_IRQ_STAT, 32'h1);
    wr(tsense_pkg::REG_IRQ_MASK, 32'h1);
    fault <= 7'h40;
    go(8'h94);
    wait_done();
    chk(irq, 1'b1);
    wr(tsense_pkg::REG_IRQ_STAT, 32'h1);
    @(posedge sys_clk);
    chk(irq, 1'b0);
    rdw(12'h05c);
    chk(w, 32'h80123456);
    fault <= 7'h00;
    temp <= 24'h000400;
    go(8'h85);
    chk({mpart, mcyc}, {5'h03, 2'h3});
    wait_done();
    ram(1'b1, 12'h200, 8'he8);
    temp <= 24'h000800;
    go(8'h80);
    wait_done();
    rdw(12'h018);
    chk(w, 32'h01000800);
    rdw(12'h020);
    chk(w, 32'h01000800);
    rdw(12'h010);
    chk(w, 32'h00000000);
    chk(n_start, 32'h5);
    go(8'h97);
    chk({slp, busy}, 2'h2);
    ram(1'b1, 12'h000, 8'h00);
    chk(slp, 1'b0);
    go(8'h95);
    chk(busy, 1'b0);
    ram(1'b1, 12'h000, 8'h3f);
    ram(1'b0, 12'h000, 8'h00);
    chk(b, 8'h1f);
    apb(1'b0, 8'h1c, 32'h0, s);
    chk(serr, 1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire
